// File: core/rrc_handler.sv
// Purpose: Decodes master command words and answers through reply registers.
// Assumes: Request inputs are synchronous to clk_sys; drive values are inputs.
// Notes: Each request is a level; its done flag follows it up and down.
`timescale 1ns/100ps
module rrc_handler (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Command words from the master.
    input wire logic [15:0] monitor_select,
    input wire logic [15:0] frequency_setpoint,
    input wire logic [15:0] instruction_word,
    input wire logic [15:0] instruction_write_data,
    // Requests from the master.
    input wire logic monitor_request,
    input wire logic volatile_freq_write_request,
    input wire logic nonvolatile_freq_write_request,
    input wire logic execute_request,
    // Reply words to the master.
    output logic [15:0] monitored_value,
    output logic [15:0] present_output_frequency,
    output logic [15:0] reply_status,
    output logic [15:0] reply_read_data,
    // Completion flags to the master.
    output logic monitoring_flag,
    output logic volatile_freq_write_done,
    output logic nonvolatile_freq_write_done,
    output logic execute_done,
    // Drive state inputs.
    input wire logic [15:0] drive_out_freq,
    input wire logic [15:0] drive_out_current,
    input wire logic [15:0] drive_out_voltage,
    input wire logic drive_running,
    input wire logic drive_alarm_event,
    input wire logic [15:0] drive_alarm_code,
    input wire logic [1:0] local_mode_request,
    // Drive controls.
    output logic [15:0] freq_volatile,
    output logic [15:0] freq_nonvolatile,
    output logic [15:0] operation_mode,
    output logic drive_reset_pulse
);
    import rrc_pkg::*;

    typedef enum logic [1:0] {RRC_IDLE, RRC_WAIT, RRC_DONE} rrc_exec_e;

    rrc_exec_e exec_state;
    logic exec_req_q;
    logic [15:0] bank_sel;
    logic [15:0] cal_mode;
    logic [15:0] alarm_hist [RRC_ALM_DEPTH];
    logic alarm_clear;
    logic par_wr_en;
    logic par_clr_keep;
    logic par_clr_all;
    logic [6:0] par_index;
    logic [15:0] par_rd_data;
    logic [15:0] next_status;
    logic [15:0] next_data;
    logic next_par_wr;
    logic next_keep;
    logic next_all;
    logic next_alarm_clear;
    logic next_reset;
    logic next_freq_v_wr;
    logic next_freq_nv_wr;
    logic next_mode_wr;
    logic next_bank_wr;
    logic next_cal_wr;
    logic [15:0] code;
    logic [15:0] wdata;

    // Folds the active bank into the low code bits to form a store index.
    function automatic logic [6:0] rrc_index(input logic [15:0] c, input logic [15:0] b);
        logic [6:0] base;
        base = c[6:0];
        rrc_index = base ^ {b[1:0] | {1'b0, b[3]}, 5'b0_0000};
        return rrc_index;
    endfunction

    // True when a code falls in the given inclusive range.
    function automatic logic rrc_in(input logic [15:0] c, input logic [15:0] lo,
                                    input logic [15:0] hi);
        return (c >= lo) && (c <= hi);
    endfunction

    assign code = instruction_word;
    assign wdata = instruction_write_data;
    assign par_index = rrc_index(code, bank_sel);

    rrc_param_store u_store (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wr_en(par_wr_en),
        .wr_index(par_index),
        .wr_data(wdata),
        .clr_keep_cal(par_clr_keep),
        .clr_all(par_clr_all),
        .rd_index(par_index),
        .rd_data(par_rd_data)
    );

    // Monitor handshake.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            monitored_value <= RRC_RST_WORD;
            monitoring_flag <= 1'b0;
        end else if (monitor_request) begin
            unique case (monitor_select)
                RRC_MON_FREQ: monitored_value <= drive_out_freq;
                RRC_MON_CURR: monitored_value <= drive_out_current;
                RRC_MON_VOLT: monitored_value <= drive_out_voltage;
                default: monitored_value <= RRC_RST_WORD;
            endcase
            monitoring_flag <= 1'b1;
        end else begin
            monitoring_flag <= 1'b0;
        end
    end

    // Output frequency reply is not gated by any handshake.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            present_output_frequency <= RRC_RST_WORD;
        end else begin
            present_output_frequency <= drive_out_freq;
        end
    end

    // Frequency handshakes and stores; instruction writes share the stores.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            freq_volatile <= RRC_RST_WORD;
            freq_nonvolatile <= RRC_RST_WORD;
            volatile_freq_write_done <= 1'b0;
            nonvolatile_freq_write_done <= 1'b0;
        end else begin
            if (volatile_freq_write_request && !volatile_freq_write_done) begin
                freq_volatile <= frequency_setpoint;
            end else if (next_freq_v_wr) begin
                freq_volatile <= wdata;
            end
            if (nonvolatile_freq_write_request && !nonvolatile_freq_write_done) begin
                freq_nonvolatile <= frequency_setpoint;
            end else if (next_freq_nv_wr) begin
                freq_nonvolatile <= wdata;
            end
            volatile_freq_write_done <= volatile_freq_write_request;
            nonvolatile_freq_write_done <= nonvolatile_freq_write_request;
        end
    end

    // Alarm history shifts newest into entry 0; an event with a clear stores the new code and clears entries 1 and up.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            for (int i = 0; i < RRC_ALM_DEPTH; i++) begin
                alarm_hist[i] <= RRC_RST_WORD;
            end
        end else if (drive_alarm_event) begin
            alarm_hist[0] <= drive_alarm_code;
            for (int i = 1; i < RRC_ALM_DEPTH; i++) begin
                alarm_hist[i] <= alarm_clear ? RRC_RST_WORD : alarm_hist[i - 1];
            end
        end else if (alarm_clear) begin
            for (int i = 0; i < RRC_ALM_DEPTH; i++) begin
                alarm_hist[i] <= RRC_RST_WORD;
            end
        end
    end

    // Operation mode, bank and calibration selectors.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            operation_mode <= RRC_MODE_NET;
            bank_sel <= RRC_RST_WORD;
            cal_mode <= RRC_RST_WORD;
        end else begin
            if (next_mode_wr) begin
                operation_mode <= wdata;
            end else if (local_mode_request != 2'b00) begin
                operation_mode <= {14'h0000, local_mode_request};
            end
            if (next_bank_wr) begin
                bank_sel <= wdata;
            end
            if (next_cal_wr) begin
                cal_mode <= wdata;
            end
        end
    end

    // Decode of the live instruction word; its results are applied only in the wait state.
    always_comb begin
        next_status = RRC_RPL_OK;
        next_data = RRC_RST_WORD;
        next_par_wr = 1'b0;
        next_keep = 1'b0;
        next_all = 1'b0;
        next_alarm_clear = 1'b0;
        next_reset = 1'b0;
        next_freq_v_wr = 1'b0;
        next_freq_nv_wr = 1'b0;
        next_mode_wr = 1'b0;
        next_bank_wr = 1'b0;
        next_cal_wr = 1'b0;
        if (code == RRC_OP_MODE_RD) begin
            next_data = operation_mode;
        end else if (code == RRC_OP_MODE_WR) begin
            if (wdata > RRC_MODE_EXT) begin
                next_status = RRC_RPL_RANGE_ERR;
            end else begin
                next_mode_wr = 1'b1;
            end
        end else if (rrc_in(code, RRC_ALM_RD_FIRST, RRC_ALM_RD_LAST)) begin
            // Low byte holds the newer entry of the pair.
            next_data = {alarm_hist[{code[1:0], 1'b1}][7:0],
                         alarm_hist[{code[1:0], 1'b0}][7:0]};
        end else if (code == RRC_FREQ_VOL_RD) begin
            next_data = freq_volatile;
        end else if (code == RRC_FREQ_NV_RD) begin
            next_data = freq_nonvolatile;
        end else if (code == RRC_FREQ_VOL_WR) begin
            next_freq_v_wr = 1'b1;
        end else if (code == RRC_FREQ_NV_WR) begin
            next_freq_nv_wr = 1'b1;
        end else if (code == RRC_CAL_RD && bank_sel == RRC_BANK_CAL) begin
            next_data = cal_mode;
        end else if (code == RRC_CAL_WR && bank_sel == RRC_BANK_CAL) begin
            if (wdata > RRC_CAL_MAX) begin
                next_status = RRC_RPL_RANGE_ERR;
            end else begin
                next_cal_wr = 1'b1;
            end
        end else if (code <= RRC_PAR_RD_LAST) begin
            next_data = par_rd_data;
        end else if (rrc_in(code, RRC_PAR_WR_FIRST, RRC_PAR_WR_LAST)) begin
            if (drive_running && operation_mode == RRC_MODE_NET) begin
                next_status = RRC_RPL_WR_ERR;
            end else begin
                next_par_wr = 1'b1;
            end
        end else if (code == RRC_ALM_CLEAR && wdata == RRC_KEY_CLEAR) begin
            next_alarm_clear = 1'b1;
        end else if (code == RRC_PAR_CLEAR && wdata == RRC_KEY_CLEAR) begin
            next_keep = 1'b1;
        end else if (code == RRC_PAR_CLEAR && wdata == RRC_KEY_ALL) begin
            next_all = 1'b1;
        end else if (code == RRC_DRIVE_RESET && wdata == RRC_KEY_CLEAR) begin
            next_reset = 1'b1;
        end else if (code == RRC_BANK_RD) begin
            next_data = bank_sel;
        end else if (code == RRC_BANK_WR) begin
            if (wdata > RRC_BANK_MAX_LOW && wdata != RRC_BANK_CAL) begin
                next_status = RRC_RPL_RANGE_ERR;
            end else begin
                next_bank_wr = 1'b1;
            end
        end else begin
            next_status = RRC_RPL_SEL_ERR;
        end
        // A code left loaded between requests must not keep rewriting the selectors.
        if (exec_state != RRC_WAIT) begin
            next_freq_v_wr = 1'b0;
            next_freq_nv_wr = 1'b0;
            next_mode_wr = 1'b0;
            next_bank_wr = 1'b0;
            next_cal_wr = 1'b0;
        end
    end

    // Execute handshake: one pass per rising request.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            exec_state <= RRC_IDLE;
            exec_req_q <= 1'b0;
            execute_done <= 1'b0;
            reply_status <= RRC_RPL_OK;
            reply_read_data <= RRC_RST_WORD;
            alarm_clear <= 1'b0;
            par_wr_en <= 1'b0;
            par_clr_keep <= 1'b0;
            par_clr_all <= 1'b0;
            drive_reset_pulse <= 1'b0;
        end else begin
            exec_req_q <= execute_request;
            alarm_clear <= 1'b0;
            par_wr_en <= 1'b0;
            par_clr_keep <= 1'b0;
            par_clr_all <= 1'b0;
            drive_reset_pulse <= 1'b0;
            unique case (exec_state)
                RRC_IDLE: begin
                    if (execute_request && !exec_req_q) begin
                        exec_state <= RRC_WAIT;
                    end
                end
                RRC_WAIT: begin
                    reply_status <= next_status;
                    if (next_status == RRC_RPL_OK) begin
                        reply_read_data <= next_data;
                    end
                    alarm_clear <= next_alarm_clear;
                    par_wr_en <= next_par_wr;
                    par_clr_keep <= next_keep;
                    par_clr_all <= next_all;
                    drive_reset_pulse <= next_reset;
                    execute_done <= 1'b1;
                    exec_state <= RRC_DONE;
                end
                RRC_DONE: begin
                    if (!execute_request) begin
                        execute_done <= 1'b0;
                        exec_state <= RRC_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// File: common/rrc_pkg.sv
// Purpose: Shared constants for the remote register command handler.
// Assumes: 16-bit register words, one 20 MHz system clock.
// Notes: Instruction codes, reply codes and monitor selectors live here.
package rrc_pkg;
    localparam int RRC_W = 16;
    // Instruction codes.
    localparam logic [15:0] RRC_OP_MODE_RD = 16'h007B;
    localparam logic [15:0] RRC_OP_MODE_WR = 16'h00FB;
    localparam logic [15:0] RRC_ALM_RD_FIRST = 16'h0074;
    localparam logic [15:0] RRC_ALM_RD_LAST = 16'h0077;
    localparam logic [15:0] RRC_FREQ_VOL_RD = 16'h006D;
    localparam logic [15:0] RRC_FREQ_NV_RD = 16'h006E;
    localparam logic [15:0] RRC_FREQ_VOL_WR = 16'h00ED;
    localparam logic [15:0] RRC_FREQ_NV_WR = 16'h00EE;
    localparam logic [15:0] RRC_PAR_RD_LAST = 16'h006C;
    localparam logic [15:0] RRC_PAR_WR_FIRST = 16'h0080;
    localparam logic [15:0] RRC_PAR_WR_LAST = 16'h00EC;
    localparam logic [15:0] RRC_ALM_CLEAR = 16'h00F4;
    localparam logic [15:0] RRC_PAR_CLEAR = 16'h00FC;
    localparam logic [15:0] RRC_DRIVE_RESET = 16'h00FD;
    localparam logic [15:0] RRC_BANK_RD = 16'h007E;
    localparam logic [15:0] RRC_BANK_WR = 16'h00FF;
    localparam logic [15:0] RRC_CAL_RD = 16'h006C;
    localparam logic [15:0] RRC_CAL_WR = 16'h00EC;
    // Key data values.
    localparam logic [15:0] RRC_KEY_CLEAR = 16'h9696;
    localparam logic [15:0] RRC_KEY_ALL = 16'h9966;
    // Operation modes.
    localparam logic [15:0] RRC_MODE_NET = 16'h0000;
    localparam logic [15:0] RRC_MODE_EXT = 16'h0001;
    localparam logic [15:0] RRC_MODE_PANEL = 16'h0002;
    // Reply codes.
    localparam logic [15:0] RRC_RPL_OK = 16'h0000;
    localparam logic [15:0] RRC_RPL_WR_ERR = 16'h0001;
    localparam logic [15:0] RRC_RPL_SEL_ERR = 16'h0002;
    localparam logic [15:0] RRC_RPL_RANGE_ERR = 16'h0003;
    // Monitor selectors.
    localparam logic [15:0] RRC_MON_ZERO = 16'h0000;
    localparam logic [15:0] RRC_MON_FREQ = 16'h0001;
    localparam logic [15:0] RRC_MON_CURR = 16'h0002;
    localparam logic [15:0] RRC_MON_VOLT = 16'h0003;
    // Parameter banks and calibration modes.
    localparam logic [15:0] RRC_BANK_MAX_LOW = 16'h0003;
    localparam logic [15:0] RRC_BANK_CAL = 16'h0009;
    localparam logic [15:0] RRC_CAL_MAX = 16'h0002;
    // Storage sizes and reset values.
    localparam int RRC_ALM_DEPTH = 8;
    localparam int RRC_PAR_DEPTH = 128;
    localparam logic [15:0] RRC_RST_WORD = 16'h0000;
    // Parameter store access takes this many cycles.
    localparam int RRC_PAR_LAT = 1;
endpackage

// File: core/rrc_param_store.sv
// Purpose: Flip-flop store of parameter words addressed by bank and code.
// Assumes: One write port, one combinational read port.
// Notes: The restore clear keeps indexes 120 and up; the full clear wipes all.
`timescale 1ns/100ps
module rrc_param_store (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Write port.
    input wire logic wr_en,
    input wire logic [6:0] wr_index,
    input wire logic [15:0] wr_data,
    // Clear controls.
    input wire logic clr_keep_cal,
    input wire logic clr_all,
    // Read port.
    input wire logic [6:0] rd_index,
    output logic [15:0] rd_data
);
    import rrc_pkg::*;

    logic [15:0] mem [RRC_PAR_DEPTH];

    // Indexes 120 and up hold calibration values and survive the restore clear.
    genvar g;
    generate
        for (g = 0; g < RRC_PAR_DEPTH; g++) begin : g_word
            always_ff @(posedge clk_sys) begin
                if (!rstn || clr_all || (clr_keep_cal && g < 120)) begin
                    mem[g] <= RRC_RST_WORD;
                end else if (wr_en && wr_index == 7'(g)) begin
                    mem[g] <= wr_data;
                end
            end
        end
    endgenerate

    assign rd_data = mem[rd_index];
endmodule

// File: verif/rrc_handler_checker.sv
// Purpose: Concurrent checks on the handler's request and reply ports.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Bound to every handler instance.
`timescale 1ns/100ps
module rrc_handler_checker import rrc_pkg::*; (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Command words and requests.
    input wire logic [15:0] monitor_select,
    input wire logic [15:0] frequency_setpoint,
    input wire logic [15:0] instruction_word,
    input wire logic [15:0] instruction_write_data,
    input wire logic monitor_request,
    input wire logic volatile_freq_write_request,
    input wire logic nonvolatile_freq_write_request,
    input wire logic execute_request,
    // Replies and flags.
    input wire logic [15:0] monitored_value,
    input wire logic [15:0] present_output_frequency,
    input wire logic [15:0] reply_status,
    input wire logic [15:0] reply_read_data,
    input wire logic monitoring_flag,
    input wire logic volatile_freq_write_done,
    input wire logic nonvolatile_freq_write_done,
    input wire logic execute_done,
    // Drive side.
    input wire logic [15:0] drive_out_freq,
    input wire logic [15:0] freq_volatile,
    input wire logic [15:0] freq_nonvolatile,
    input wire logic drive_reset_pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_exec_rise;
        !execute_request ##1 execute_request;
    endsequence
    sequence s_exec_answer;
        !execute_done ##1 execute_done;
    endsequence
    AST_MON_FLAG: assert property (monitor_request |=> monitoring_flag)
        else $error("monitoring flag missing after monitor request");
    AST_MON_FREQ: assert property (monitor_request && monitor_select == RRC_MON_FREQ
        |=> monitored_value == $past(drive_out_freq))
        else $error("monitored frequency differs from drive frequency");
    AST_FLAG_DROP: assert property (!monitor_request |=> !monitoring_flag)
        else $error("monitoring flag held after request dropped");
    AST_VOL_WR: assert property ($rose(volatile_freq_write_request)
        |=> volatile_freq_write_done && freq_volatile == $past(frequency_setpoint))
        else $error("volatile frequency write not completed");
    AST_NV_WR: assert property ($rose(nonvolatile_freq_write_request)
        |=> nonvolatile_freq_write_done && freq_nonvolatile == $past(frequency_setpoint))
        else $error("nonvolatile frequency write not completed");
    AST_OUT_FREQ: assert property ($past(rstn) |-> present_output_frequency == $past(drive_out_freq))
        else $error("output frequency reply not refreshed");
    AST_EXEC_ANSWER: assert property (s_exec_rise |=> s_exec_answer)
        else $error("execute done not raised on time");
    AST_EXEC_DROP: assert property (!execute_request |=> !execute_done)
        else $error("execute done held after request dropped");
    AST_EXEC_ONCE: assert property (execute_done |=> $stable(reply_status) && $stable(reply_read_data))
        else $error("reply changed while request held");
    AST_RESET_PULSE: assert property (drive_reset_pulse |-> ($rose(execute_done)
        && instruction_word == RRC_DRIVE_RESET && instruction_write_data == RRC_KEY_CLEAR)
        ##1 !drive_reset_pulse)
        else $error("drive reset pulse without its command");
endmodule
bind rrc_handler rrc_handler_checker u_checker (.clk_sys, .rstn, .monitor_select,
    .frequency_setpoint, .instruction_word, .instruction_write_data, .monitor_request,
    .volatile_freq_write_request, .nonvolatile_freq_write_request, .execute_request,
    .monitored_value, .present_output_frequency, .reply_status, .reply_read_data,
    .monitoring_flag, .volatile_freq_write_done, .nonvolatile_freq_write_done, .execute_done,
    .drive_out_freq, .freq_volatile, .freq_nonvolatile, .drive_reset_pulse);

// File: verif/rrc_master_model.sv
// Purpose: Master station model that raises requests and waits for their flags.
// Assumes: Command words are loaded by the bench before a request is raised.
// Notes: A request is held until its flag rises or 20 edges pass, plus an optional dwell.
`timescale 1ns/100ps
module rrc_master_model (
    // Clock.
    input wire logic clk_sys,
    // Requests to the handler.
    output logic monitor_request,
    output logic volatile_freq_write_request,
    output logic nonvolatile_freq_write_request,
    output logic execute_request,
    // Completion flags from the handler.
    input wire logic monitoring_flag,
    input wire logic volatile_freq_write_done,
    input wire logic nonvolatile_freq_write_done,
    input wire logic execute_done
);
    logic [3:0] rq = 4'h0;
    wire logic [3:0] fl = {execute_done, nonvolatile_freq_write_done,
        volatile_freq_write_done, monitoring_flag};
    assign {execute_request, nonvolatile_freq_write_request} = rq[3:2];
    assign {volatile_freq_write_request, monitor_request} = rq[1:0];
    // Two idle edges first let the words settle and the previous flag drop.
    task automatic req(input int which, input int hold);
        int n;
        repeat (2) @(posedge clk_sys);
        rq[which] <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (fl[which] !== 1'b1 && n < 20);
        repeat (hold) @(posedge clk_sys);
        rq[which] <= 1'b0;
    endtask
endmodule

// File: verif/rrc_handler_tb.sv
// Purpose: Self-checking bench for the remote register command handler.
// Assumes: The master model raises one request at a time.
// Notes: Expected replies come from an integer model of store and history.
`timescale 1ns/100ps
module rrc_handler_tb;
    import rrc_pkg::*;
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
    logic clk_sys = 1'b0;
    logic rstn, drive_running, drive_alarm_event, drive_reset_pulse;
    logic [1:0] local_mode_request;
    logic [15:0] drive_out_freq, drive_out_current, drive_out_voltage, drive_alarm_code;
    logic [15:0] monitor_select, frequency_setpoint, instruction_word, instruction_write_data;
    logic monitor_request, volatile_freq_write_request, nonvolatile_freq_write_request;
    logic execute_request, monitoring_flag, volatile_freq_write_done;
    logic nonvolatile_freq_write_done, execute_done;
    logic [15:0] monitored_value, present_output_frequency, reply_status, reply_read_data;
    logic [15:0] freq_volatile, freq_nonvolatile, operation_mode, v;
    int mismatches = 0, total_checks = 0, seed = 32'hd4d6, pulses = 0;
    int par [128], alm [$], i, k, e;
    int banks [5] = '{0, 1, 2, 3, 9};
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (drive_reset_pulse === 1'b1) pulses++;
    rrc_handler DUT (.clk_sys, .rstn, .monitor_select, .frequency_setpoint, .instruction_word,
        .instruction_write_data, .monitor_request, .volatile_freq_write_request,
        .nonvolatile_freq_write_request, .execute_request, .monitored_value,
        .present_output_frequency, .reply_status, .reply_read_data, .monitoring_flag,
        .volatile_freq_write_done, .nonvolatile_freq_write_done, .execute_done, .drive_out_freq,
        .drive_out_current, .drive_out_voltage, .drive_running, .drive_alarm_event,
        .drive_alarm_code, .local_mode_request, .freq_volatile, .freq_nonvolatile,
        .operation_mode, .drive_reset_pulse);
    rrc_master_model master (.clk_sys, .monitor_request, .volatile_freq_write_request,
        .nonvolatile_freq_write_request, .execute_request, .monitoring_flag,
        .volatile_freq_write_done, .nonvolatile_freq_write_done, .execute_done);
    function automatic int alm_at(input int j);
        return (j < alm.size()) ? alm[j] : 0;
    endfunction
    task automatic exec(input logic [15:0] code, input logic [15:0] data, input int hold);
        @(posedge clk_sys);
        instruction_word <= code;
        instruction_write_data <= data;
        master.req(3, hold);
    endtask
    // A negative expected read value means the read data is not compared.
    task automatic do_exec(input logic [15:0] code, input logic [15:0] data, input int es,
                           input int er);
        exec(code, data, 0);
        `CHK(reply_status, es[15:0])
        if (er >= 0) `CHK(reply_read_data, er[15:0])
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        complete_run();
    end
    initial begin
        rstn = 1'b0;
        {drive_running, drive_alarm_event, local_mode_request} = 4'h0;
        {drive_out_freq, drive_out_current, drive_out_voltage, drive_alarm_code} = 64'h0;
        {monitor_select, frequency_setpoint, instruction_word, instruction_write_data} = 64'h0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        `CHK({execute_done, reply_status, operation_mode}, 33'h0)
        for (i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            drive_out_freq <= 16'($random(seed));
            drive_out_current <= 16'($random(seed));
            drive_out_voltage <= 16'($random(seed));
            monitor_select <= 16'(i);
            master.req(0, 0);
            v = (i == 0) ? 16'h0000 : (i == 1) ? drive_out_freq : drive_out_current;
            v = (i == 3) ? drive_out_voltage : v;
            `CHK(monitored_value, v)
            `CHK(present_output_frequency, drive_out_freq)
        end
        for (i = 0; i < 2; i++) begin
            k = $random(seed) & 32'hffff;
            @(posedge clk_sys);
            frequency_setpoint <= k[15:0];
            master.req(1 + i, 0);
            `CHK(i ? freq_nonvolatile : freq_volatile, k[15:0])
            e = $random(seed) & 32'hffff;
            do_exec(RRC_FREQ_VOL_WR + 16'(i), e[15:0], 0, -1);
            `CHK(i ? freq_nonvolatile : freq_volatile, e[15:0])
            do_exec(RRC_FREQ_VOL_RD + 16'(i), 16'h0000, 0, e);
        end
        for (i = 0; i < 6; i++) begin
            k = $random(seed) & 32'h3f;
            e = $random(seed) & 32'hffff;
            par[k] = e;
            do_exec(RRC_PAR_WR_FIRST + 16'(k), e[15:0], 0, -1);
            do_exec(16'(k), 16'h0000, 0, par[k]);
        end
        do_exec(RRC_PAR_CLEAR, RRC_KEY_CLEAR, 0, -1);
        do_exec(16'(k), 16'h0000, 0, 0);
        do_exec(RRC_PAR_WR_FIRST + 16'(k), 16'h0005, 0, -1);
        do_exec(RRC_PAR_CLEAR, RRC_KEY_ALL, 0, -1);
        do_exec(16'(k), 16'h0000, 0, 0);
        for (i = 0; i < 9; i++) begin
            e = $random(seed) & 32'hff;
            alm.push_front(e);
            @(posedge clk_sys);
            drive_alarm_code <= 16'(e);
            drive_alarm_event <= 1'b1;
            @(posedge clk_sys);
            drive_alarm_event <= 1'b0;
        end
        for (i = 0; i < 4; i++) begin
            k = alm_at(2 * i + 1) * 256 + alm_at(2 * i);
            do_exec(RRC_ALM_RD_FIRST + 16'(i), 16'h0000, 0, k);
        end
        do_exec(RRC_ALM_CLEAR, RRC_KEY_CLEAR, 0, -1);
        do_exec(RRC_ALM_RD_FIRST, 16'h0000, 0, 0);
        foreach (banks[j]) begin
            do_exec(RRC_BANK_WR, 16'(banks[j]), 0, -1);
            do_exec(RRC_BANK_RD, 16'h0000, 0, banks[j]);
        end
        do_exec(RRC_BANK_WR, 16'h0004, RRC_RPL_RANGE_ERR, -1);
        for (i = 0; i < 4; i++) begin
            do_exec(RRC_CAL_WR, 16'(i), (i > 2) ? 3 : 0, -1);
            do_exec(RRC_CAL_RD, 16'h0000, 0, (i > 2) ? 2 : i);
        end
        do_exec(RRC_BANK_WR, 16'h0000, 0, -1);
        do_exec(RRC_OP_MODE_WR, RRC_MODE_EXT, 0, -1);
        do_exec(RRC_OP_MODE_RD, 16'h0000, 0, 1);
        do_exec(RRC_OP_MODE_WR, RRC_MODE_PANEL, RRC_RPL_RANGE_ERR, -1);
        local_mode_request <= 2'd2;
        do_exec(RRC_OP_MODE_RD, 16'h0000, 0, 2);
        local_mode_request <= 2'd0;
        do_exec(RRC_OP_MODE_WR, RRC_MODE_NET, 0, -1);
        `CHK(operation_mode, RRC_MODE_NET)
        instruction_word <= RRC_OP_MODE_WR;
        instruction_write_data <= RRC_MODE_EXT;
        repeat (3) @(posedge clk_sys);
        `CHK(operation_mode, RRC_MODE_NET)
        drive_running <= 1'b1;
        do_exec(RRC_PAR_WR_FIRST, 16'h0001, RRC_RPL_WR_ERR, -1);
        drive_running <= 1'b0;
        do_exec(16'h0078, 16'h0000, RRC_RPL_SEL_ERR, -1);
        // The request is held long after done to show the reset runs only once.
        exec(RRC_DRIVE_RESET, RRC_KEY_CLEAR, 8);
        repeat (4) @(posedge clk_sys);
        `CHK(pulses, 1)
        complete_run();
    end
endmodule
